/* serial_cmd_map.svh */
// Addresses, codes, field positions, reset values and timing counts
// for the serial slave command handler. Definitions only.
`ifndef SERIAL_CMD_MAP_SVH
`define SERIAL_CMD_MAP_SVH
// Register addresses
`define ADDR_ZERO        16'h0000
`define ADDR_OP_WORD     16'h0001
`define ADDR_SPEED       16'h0002
`define ADDR_STATUS      16'h0020
`define ADDR_PARAM_BASE  16'h0100
`define PARAM_COUNT      16'h0010
`define ADDR_COMMIT_NV   16'h0900
`define ADDR_COMMIT_RAM  16'h0910
// Function codes
`define FN_READ          8'h03
`define FN_LOOP          8'h08
`define FN_WRITE         8'h10
`define FN_EXC_FLAG      8'h80
// Exception codes
`define ERR_NONE         8'h00
`define ERR_FUNC         8'h01
`define ERR_ADDR         8'h02
`define ERR_QTY          8'h03
`define ERR_DATA         8'h21
`define ERR_MODE         8'h22
`define ERR_UV           8'h23
`define ERR_BUSY         8'h24
// Framing
`define BCAST_SLAVE      8'h00
`define BCAST_LAST       16'h0002
`define QTY_MAX          16'h0010
`define LEN_FIXED        8'h08
`define LEN_WR_HDR       9'h009
`define LEN_MIN          8'h04
`define DATA_FIRST       8'h07
`define DATA_BYTES       8'h20
`define COMMIT_VALUE     16'h0000
// Operation word fields
`define OP_DEFINED_MASK  16'hF033
`define OP_BIT_RUN       0
`define OP_BIT_REV       1
`define OP_BIT_EXT_FAULT 4
`define OP_BIT_FLT_RST   5
`define OP_BIT_CONTACT_A 12
`define OP_BIT_CONTACT_B 13
`define OP_BIT_CONTACT_C 14
`define OP_BIT_CONTACT_D 15
// Reset values and limits
`define OP_WORD_RST      16'h0000
`define SPEED_RST        16'h0000
`define PARAM_RST        16'h0000
`define SPEED_MAX        16'h7530
`define PARAM_MAX        16'h7FFF
`define NV_SAFE_LAST     4'h5
// Checksum
`define CRC_INIT         16'hFFFF
`define CRC_POLY         16'hA001
`define CRC_GOOD         16'h0000
// Self-diagnosis
`define TEST_MODE_CODE   8'h43
`define ST_PATTERN       8'h55
`define ST_BYTES         4
`define ST_TIMEOUT_US    100
`define CLK_MHZ          100
`define ST_TIMEOUT_CYC   (`ST_TIMEOUT_US * `CLK_MHZ)
`endif

/* serial_cmd_pkg.sv */
// Types shared by the serial slave command handler files.
// Assumes nothing beyond a SystemVerilog compiler.
package serial_cmd_pkg;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       err_overrun;
    logic       err_framing;
    logic       err_parity;
  } rx_byte_s;

  typedef struct packed {
    logic running;
    logic main_undervoltage_alarm;
    logic param_busy;
    logic nonvolatile_fault_warning;
  } drive_stat_s;

  typedef struct packed {
    logic run;
    logic reverse;
    logic ext_fault;
    logic fault_reset;
    logic contact_input_a;
    logic contact_input_b;
    logic contact_input_c;
    logic contact_input_d;
  } drive_ctrl_s;

  typedef logic [15:0][15:0] param_bank_t;

  typedef enum logic [1:0] {
    RSP_EXC   = 2'b00,
    RSP_READ  = 2'b01,
    RSP_LOOP  = 2'b10,
    RSP_WRITE = 2'b11
  } resp_e;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_BODY = 2'b01,
    TX_CRCL = 2'b10,
    TX_CRCH = 2'b11
  } tx_state_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEND = 3'b001,
    ST_WAIT = 3'b010,
    ST_PASS = 3'b011,
    ST_FAIL = 3'b100
  } selftest_e;
endpackage : serial_cmd_pkg

/* crc16_accum.sv */
// Byte-wise CRC-16 accumulator, reflected polynomial.
// Assumes clear and en come from logic on clk_sys.
`include "serial_cmd_map.svh"
module crc16_accum (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Byte feed
  input  wire logic        clear,
  input  wire logic        en,
  input  wire logic [7:0]  data,
  // Checksum
  output logic      [15:0] crc,
  output logic      [15:0] crc_next
);
  logic [15:0] crc_r;
  logic [15:0] crc_nxt;

  always_comb
  begin
    crc_next = crc_r ^ {8'h00, data};
    for (int k = 0; k < 8; k++)
      crc_next = crc_next[0] ? ((crc_next >> 1) ^ `CRC_POLY)
                             : (crc_next >> 1);
    crc_nxt = clear ? `CRC_INIT : (en ? crc_next : crc_r);
  end

  always_ff @(posedge clk_sys)
    crc_r <= !resetn ? `CRC_INIT : crc_nxt;

  assign crc = crc_r;
endmodule : crc16_accum

/* loopback_selftest.sv */
// Loopback self-diagnosis: sends a byte pattern and checks its echo.
// Assumes transmit is wired back to receive by the user at power-up.
`include "serial_cmd_map.svh"
module loopback_selftest #(
  parameter int TIMEOUT_CYC = `ST_TIMEOUT_CYC,
  parameter int NBYTES      = `ST_BYTES
) (
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     resetn,
  // Control
  input  wire logic                     start,
  // Link bytes
  input  wire logic                     tx_ready,
  input  wire serial_cmd_pkg::rx_byte_s rx,
  output logic                          tx_valid,
  output logic [7:0]                    tx_byte,
  // Result
  output logic                          active,
  output logic                          pass,
  output logic                          fail
);
  import serial_cmd_pkg::*;

  selftest_e   st_r, st_nxt;
  logic [7:0]  byte_r, byte_nxt;
  logic [7:0]  n_r, n_nxt;
  logic [31:0] tmr_r, tmr_nxt;

  always_comb
  begin
    st_nxt   = st_r;
    byte_nxt = byte_r;
    n_nxt    = n_r;
    tmr_nxt  = tmr_r;
    case (st_r)
      ST_IDLE:
        if (start)
        begin
          st_nxt   = ST_SEND;
          n_nxt    = 8'h00;
          byte_nxt = `ST_PATTERN;
        end
      ST_SEND:
        if (tx_ready)
        begin
          st_nxt  = ST_WAIT;
          tmr_nxt = 32'h0000_0000;
        end
      ST_WAIT:
        if (rx.valid)
        begin
          if (rx.data != byte_r || rx.err_overrun || rx.err_framing
              || rx.err_parity)
            st_nxt = ST_FAIL;
          else if (n_r == 8'(NBYTES - 1))
            st_nxt = ST_PASS;
          else
          begin
            st_nxt   = ST_SEND;
            n_nxt    = n_r + 8'h01;
            byte_nxt = ~byte_r;
          end
        end
        else if (tmr_r == 32'(TIMEOUT_CYC - 1))
          st_nxt = ST_FAIL;
        else
          tmr_nxt = tmr_r + 32'h0000_0001;
      ST_PASS, ST_FAIL: st_nxt = st_r;
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    st_r   <= !resetn ? ST_IDLE : st_nxt;
    byte_r <= !resetn ? 8'h00 : byte_nxt;
    n_r    <= !resetn ? 8'h00 : n_nxt;
    tmr_r  <= !resetn ? 32'h0000_0000 : tmr_nxt;
  end

  assign active   = (st_r == ST_SEND) || (st_r == ST_WAIT);
  assign tx_valid = (st_r == ST_SEND);
  assign tx_byte  = byte_r;
  assign pass     = (st_r == ST_PASS);
  assign fail     = (st_r == ST_FAIL);
endmodule : loopback_selftest

/* serial_slave_command_handler.sv */
// Slave command handler: parses request frames, checks them, executes
// writes and commits, and builds normal or exception replies.
// Assumes a byte receiver and transmitter on clk_sys and a frame_end
// pulse from the receiver's silence detector after each frame.
`include "serial_cmd_map.svh"
module serial_slave_command_handler #(
  parameter int ST_TIMEOUT_CYC = `ST_TIMEOUT_CYC,
  parameter int ST_BYTES       = `ST_BYTES
) (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        resetn,
  // Received bytes
  input  wire serial_cmd_pkg::rx_byte_s    rx,
  input  wire logic                        frame_end,
  // Reply bytes
  input  wire logic                        tx_ready,
  output logic                             tx_valid,
  output logic [7:0]                       tx_byte,
  // Configuration
  input  wire logic [7:0]                  slave_address,
  input  wire logic [7:0]                  input_function_select_fifth,
  input  wire logic [15:0]                 local_ctrl,
  // Drive status
  input  wire serial_cmd_pkg::drive_stat_s stat,
  // Drive control
  output logic [15:0]                      ctrl_word,
  output serial_cmd_pkg::drive_ctrl_s      ctrl,
  output logic [15:0]                      speed_setpoint,
  output serial_cmd_pkg::param_bank_t      active_param,
  output logic                             commit_pulse,
  output logic                             nv_store_pulse,
  // Self-diagnosis
  output logic                             selftest_pass,
  output logic                             comm_error_alarm,
  output logic                             fault_contact,
  output logic                             drive_ready
);
  import serial_cmd_pkg::*;

  // Test strap caught on the first edge after reset release
  logic boot_r, st_go_r;
  logic st_active, st_valid, st_pass, st_fail;
  logic [7:0] st_byte;

  always_ff @(posedge clk_sys)
  begin
    boot_r  <= resetn;
    st_go_r <= resetn && !boot_r
               && (input_function_select_fifth == `TEST_MODE_CODE);
  end

  loopback_selftest #(
    .TIMEOUT_CYC (ST_TIMEOUT_CYC),
    .NBYTES      (ST_BYTES)
  ) u_selftest (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .start    (st_go_r),
    .tx_ready (tx_ready),
    .rx       (rx),
    .tx_valid (st_valid),
    .tx_byte  (st_byte),
    .active   (st_active),
    .pass     (st_pass),
    .fail     (st_fail)
  );

  // Frame capture
  logic [7:0]  idx_r, idx_nxt, slv_r, slv_nxt, fn_r, fn_nxt, bc_r, bc_nxt;
  logic [15:0] start_r, start_nxt, cnt_r, cnt_nxt, rx_crc;
  logic        bad_r, bad_nxt, rx_take;
  logic [7:0]  doff;
  param_bank_t buf_r, buf_nxt;

  assign rx_take = rx.valid && !st_active;

  always_comb
  begin
    idx_nxt = idx_r;
    slv_nxt = slv_r;
    fn_nxt = fn_r;
    bc_nxt = bc_r;
    start_nxt = start_r;
    cnt_nxt = cnt_r;
    bad_nxt = bad_r;
    buf_nxt = buf_r;
    doff = idx_r - `DATA_FIRST;
    if (frame_end)
    begin
      idx_nxt = 8'h00;
      bad_nxt = 1'b0;
    end
    else if (rx_take)
    begin
      if (idx_r != 8'hFF)
        idx_nxt = idx_r + 8'h01;
      bad_nxt = bad_r | rx.err_overrun | rx.err_framing | rx.err_parity;
      case (idx_r)
        8'h00: slv_nxt = rx.data;
        8'h01: fn_nxt = rx.data;
        8'h02: start_nxt[15:8] = rx.data;
        8'h03: start_nxt[7:0] = rx.data;
        8'h04: cnt_nxt[15:8] = rx.data;
        8'h05: cnt_nxt[7:0] = rx.data;
        8'h06: bc_nxt = rx.data;
        default:
          if (doff < `DATA_BYTES)
          begin
            if (doff[0])
              buf_nxt[doff[4:1]][7:0] = rx.data;
            else
              buf_nxt[doff[4:1]][15:8] = rx.data;
          end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    idx_r   <= !resetn ? 8'h00 : idx_nxt;
    bad_r   <= !resetn ? 1'b0 : bad_nxt;
    slv_r   <= slv_nxt;
    fn_r    <= fn_nxt;
    bc_r    <= bc_nxt;
    start_r <= start_nxt;
    cnt_r   <= cnt_nxt;
    buf_r   <= buf_nxt;
  end

  crc16_accum u_rx_crc (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .clear    (frame_end),
    .en       (rx_take),
    .data     (rx.data),
    .crc      (rx_crc),
    .crc_next ()
  );

  // Frame check and exception code
  logic        bcast, len_ok, frame_ok, qty_bad, exec, go_reply;
  logic        f_addr, f_ro, f_uv, f_busy, f_lim;
  logic        is_op, is_sp, is_st, is_pr, is_cm;
  logic [15:0] a, off, w;
  logic [7:0]  err_code;

  always_comb
  begin
    bcast = (slv_r == `BCAST_SLAVE);
    case (fn_r)
      `FN_READ, `FN_LOOP: len_ok = (idx_r == `LEN_FIXED);
      `FN_WRITE: len_ok = ({1'b0, idx_r} == `LEN_WR_HDR + {1'b0, bc_r});
      default: len_ok = (idx_r >= `LEN_MIN);
    endcase
    frame_ok = frame_end && !st_active && !bad_r && rx_crc == `CRC_GOOD
               && len_ok && (slv_r == slave_address || bcast);
    qty_bad = (cnt_r == 16'h0000) || (cnt_r > `QTY_MAX);
    {f_addr, f_ro, f_uv, f_busy, f_lim} = 5'b0_0000;
    {is_op, is_sp, is_st, is_pr, is_cm} = 5'b0_0000;
    a = 16'h0000;
    off = 16'h0000;
    w = 16'h0000;
    for (int i = 0; i < 16; i++)
    begin
      a = start_r + 16'(i);
      off = a - `ADDR_PARAM_BASE;
      w = buf_r[i];
      is_op = (a == `ADDR_OP_WORD);
      is_sp = (a == `ADDR_SPEED);
      is_st = (a == `ADDR_STATUS);
      is_pr = (off < `PARAM_COUNT);
      is_cm = (a == `ADDR_COMMIT_NV) || (a == `ADDR_COMMIT_RAM);
      if (16'(i) < cnt_r && fn_r == `FN_READ)
      begin
        if (!(is_op || is_sp || is_st || is_pr))
          f_addr = 1'b1;
      end
      else if (16'(i) < cnt_r && fn_r == `FN_WRITE)
      begin
        if (!(is_op || is_sp || is_st || is_pr || is_cm
              || (bcast && a == `ADDR_ZERO)))
          f_addr = 1'b1;
        if (is_st || ((is_pr || is_cm) && stat.running))
          f_ro = 1'b1;
        if (is_pr && stat.nonvolatile_fault_warning
            && off[3:0] > `NV_SAFE_LAST)
          f_ro = 1'b1;
        if ((is_pr || is_cm) && stat.main_undervoltage_alarm)
          f_uv = 1'b1;
        if (is_pr && stat.param_busy)
          f_busy = 1'b1;
        if ((is_sp && w > `SPEED_MAX) || (is_pr && w > `PARAM_MAX)
            || (is_cm && w != `COMMIT_VALUE))
          f_lim = 1'b1;
      end
    end
    if (fn_r != `FN_READ && fn_r != `FN_LOOP && fn_r != `FN_WRITE)
      err_code = `ERR_FUNC;
    else if (fn_r != `FN_LOOP && qty_bad)
      err_code = `ERR_QTY;
    else if (fn_r == `FN_WRITE && {8'h00, bc_r} != {cnt_r[14:0], 1'b0})
      err_code = `ERR_QTY;
    else if ((bcast && start_r > `BCAST_LAST) || f_addr)
      err_code = `ERR_ADDR;
    else if (f_ro)
      err_code = `ERR_MODE;
    else if (f_uv)
      err_code = `ERR_UV;
    else if (f_busy)
      err_code = `ERR_BUSY;
    else if (f_lim)
      err_code = `ERR_DATA;
    else
      err_code = `ERR_NONE;
    exec = frame_ok && err_code == `ERR_NONE && fn_r == `FN_WRITE;
    go_reply = frame_ok && !bcast;
  end

  // Write execution, staging and commit
  logic [15:0] op_r, op_nxt, speed_r, speed_nxt, ctrl_r, ctrl_nxt;
  param_bank_t staged_r, staged_nxt, active_r, active_nxt;
  logic        commit_r, commit_nxt, nv_r, nv_nxt;

  always_comb
  begin : exec_c
    logic [15:0] ea;
    logic [15:0] eoff;
    ea = 16'h0000;
    eoff = 16'h0000;
    op_nxt = op_r;
    speed_nxt = speed_r;
    staged_nxt = staged_r;
    active_nxt = active_r;
    commit_nxt = 1'b0;
    nv_nxt = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      ea = start_r + 16'(i);
      eoff = ea - `ADDR_PARAM_BASE;
      if (exec && 16'(i) < cnt_r)
      begin
        if (ea == `ADDR_OP_WORD)
          op_nxt = buf_r[i];
        if (ea == `ADDR_SPEED)
          speed_nxt = buf_r[i];
        if (eoff < `PARAM_COUNT)
          staged_nxt[eoff[3:0]] = buf_r[i];
        if (ea == `ADDR_COMMIT_NV || ea == `ADDR_COMMIT_RAM)
          commit_nxt = 1'b1;
        if (ea == `ADDR_COMMIT_NV)
          nv_nxt = 1'b1;
      end
    end
    if (commit_nxt)
      active_nxt = staged_nxt;
    ctrl_nxt = (op_nxt & `OP_DEFINED_MASK)
               | (local_ctrl & ~`OP_DEFINED_MASK);
  end

  always_ff @(posedge clk_sys)
  begin
    op_r     <= !resetn ? `OP_WORD_RST : op_nxt;
    speed_r  <= !resetn ? `SPEED_RST : speed_nxt;
    ctrl_r   <= !resetn ? `OP_WORD_RST : ctrl_nxt;
    staged_r <= !resetn ? {16{`PARAM_RST}} : staged_nxt;
    active_r <= !resetn ? {16{`PARAM_RST}} : active_nxt;
    commit_r <= !resetn ? 1'b0 : commit_nxt;
    nv_r     <= !resetn ? 1'b0 : nv_nxt;
  end

  assign ctrl_word         = ctrl_r;
  assign ctrl.run          = ctrl_r[`OP_BIT_RUN];
  assign ctrl.reverse      = ctrl_r[`OP_BIT_REV];
  assign ctrl.ext_fault    = ctrl_r[`OP_BIT_EXT_FAULT];
  assign ctrl.fault_reset  = ctrl_r[`OP_BIT_FLT_RST];
  assign ctrl.contact_input_a = ctrl_r[`OP_BIT_CONTACT_A];
  assign ctrl.contact_input_b = ctrl_r[`OP_BIT_CONTACT_B];
  assign ctrl.contact_input_c = ctrl_r[`OP_BIT_CONTACT_C];
  assign ctrl.contact_input_d = ctrl_r[`OP_BIT_CONTACT_D];
  assign speed_setpoint    = speed_r;
  assign active_param      = active_r;
  assign commit_pulse      = commit_r;
  assign nv_store_pulse    = nv_r;

  // Reply transmitter
  tx_state_e   tx_r, tx_nxt;
  resp_e       kind_r, kind_nxt;
  logic [7:0]  ti_r, ti_nxt, tb_r, tb_nxt, crch_r, crch_nxt;
  logic [7:0]  code_r, code_nxt, rfn_r, rfn_nxt, gi, gd, gb, last;
  logic [15:0] rst_r, rst_nxt, rcnt_r, rcnt_nxt, ra, roff, rw, tx_crc;
  logic        tx_take;

  assign tx_take = (tx_r == TX_BODY) && tx_ready && !st_active;

  always_comb
  begin
    gi = ti_r + 8'h01;
    gd = gi - 8'h03;
    ra = rst_r + {12'h000, gd[4:1]};
    roff = ra - `ADDR_PARAM_BASE;
    if (ra == `ADDR_OP_WORD)
      rw = op_r;
    else if (ra == `ADDR_SPEED)
      rw = speed_r;
    else if (ra == `ADDR_STATUS)
      rw = {12'h000, stat};
    else if (roff < `PARAM_COUNT)
      rw = staged_r[roff[3:0]];
    else
      rw = 16'h0000;
    case (kind_r)
      RSP_EXC:
      begin
        gb = (gi == 8'h01) ? (rfn_r | `FN_EXC_FLAG) : code_r;
        last = 8'h02;
      end
      RSP_READ:
      begin
        gb = (gi == 8'h01) ? rfn_r : (gi == 8'h02) ? {rcnt_r[6:0], 1'b0}
             : (gd[0] ? rw[7:0] : rw[15:8]);
        last = {rcnt_r[6:0], 1'b0} + 8'h02;
      end
      default:
      begin
        case (gi)
          8'h01: gb = rfn_r;
          8'h02: gb = rst_r[15:8];
          8'h03: gb = rst_r[7:0];
          8'h04: gb = rcnt_r[15:8];
          default: gb = rcnt_r[7:0];
        endcase
        last = 8'h05;
      end
    endcase
  end

  always_comb
  begin
    tx_nxt = tx_r;
    kind_nxt = kind_r;
    ti_nxt = ti_r;
    tb_nxt = tb_r;
    crch_nxt = crch_r;
    code_nxt = code_r;
    rfn_nxt = rfn_r;
    rst_nxt = rst_r;
    rcnt_nxt = rcnt_r;
    case (tx_r)
      TX_IDLE:
        if (go_reply)
        begin
          tx_nxt = TX_BODY;
          ti_nxt = 8'h00;
          tb_nxt = slv_r;
          code_nxt = err_code;
          rfn_nxt = fn_r;
          rst_nxt = start_r;
          rcnt_nxt = cnt_r;
          if (err_code != `ERR_NONE)
            kind_nxt = RSP_EXC;
          else if (fn_r == `FN_READ)
            kind_nxt = RSP_READ;
          else if (fn_r == `FN_LOOP)
            kind_nxt = RSP_LOOP;
          else
            kind_nxt = RSP_WRITE;
        end
      TX_BODY:
        if (tx_take && ti_r == last)
        begin
          tx_nxt = TX_CRCL;
          tb_nxt = tx_crc[7:0];
          crch_nxt = tx_crc[15:8];
        end
        else if (tx_take)
        begin
          ti_nxt = gi;
          tb_nxt = gb;
        end
      TX_CRCL:
        if (tx_ready && !st_active)
        begin
          tx_nxt = TX_CRCH;
          tb_nxt = crch_r;
        end
      TX_CRCH:
        if (tx_ready && !st_active)
          tx_nxt = TX_IDLE;
      default: tx_nxt = TX_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    tx_r   <= !resetn ? TX_IDLE : tx_nxt;
    kind_r <= !resetn ? RSP_EXC : kind_nxt;
    ti_r   <= !resetn ? 8'h00 : ti_nxt;
    tb_r   <= !resetn ? 8'h00 : tb_nxt;
    crch_r <= !resetn ? 8'h00 : crch_nxt;
    code_r <= !resetn ? 8'h00 : code_nxt;
    rfn_r  <= !resetn ? 8'h00 : rfn_nxt;
    rst_r  <= !resetn ? 16'h0000 : rst_nxt;
    rcnt_r <= !resetn ? 16'h0000 : rcnt_nxt;
  end

  crc16_accum u_tx_crc (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .clear    (tx_r == TX_IDLE),
    .en       (tx_take),
    .data     (tb_r),
    .crc      (),
    .crc_next (tx_crc)
  );

  assign tx_valid = st_active ? st_valid : (tx_r != TX_IDLE);
  assign tx_byte  = st_active ? st_byte : tb_r;

  assign selftest_pass    = st_pass;
  assign comm_error_alarm = st_fail;
  assign fault_contact    = st_fail;
  assign drive_ready      = !st_fail && !st_active;
endmodule : serial_slave_command_handler

/* serial_cmd_properties.sv */
// Checker for the serial slave command handler.
// Sees only the handler's top ports; bound below.
module cmd_checker (
  // Clock and reset
  input wire logic                        clk_sys,
  input wire logic                        resetn,
  // Link
  input wire logic                        frame_end,
  input wire logic                        tx_ready,
  input wire logic                        tx_valid,
  input wire logic [7:0]                  tx_byte,
  // Control
  input wire logic [15:0]                 local_ctrl,
  input wire logic [15:0]                 ctrl_word,
  input wire serial_cmd_pkg::drive_ctrl_s ctrl,
  input wire logic                        commit_pulse,
  input wire logic                        nv_store_pulse,
  // Status
  input wire logic                        drive_ready,
  input wire logic                        comm_error_alarm,
  input wire logic                        fault_contact
);
  timeunit 1ns;
  timeprecision 1ps;
  import serial_cmd_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  ctrl_map_a: assert property (
    ctrl == {ctrl_word[0], ctrl_word[1], ctrl_word[4], ctrl_word[5],
    ctrl_word[12], ctrl_word[13], ctrl_word[14], ctrl_word[15]})
    else $error("control fields off");
  local_keep_a: assert property ($past(resetn) |->
    (ctrl_word & 16'h0FCC) == ($past(local_ctrl) & 16'h0FCC))
    else $error("local bits lost");
  commit_time_a: assert property (commit_pulse |->
    $past(frame_end) || $past(frame_end, 2)) else $error("stray commit");
  nv_commit_a: assert property (nv_store_pulse |-> commit_pulse)
    else $error("store without commit");
  commit_once_a: assert property (commit_pulse |=> !commit_pulse)
    else $error("commit too long");
  reply_start_a: assert property (
    $rose(tx_valid) && drive_ready && $past(drive_ready) |->
    $past(frame_end)) else $error("reply without frame");
  tx_hold_a: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_byte)) else $error("reply byte dropped");
  test_fail_a: assert property (comm_error_alarm |->
    fault_contact && !drive_ready) else $error("alarm without fault");
endmodule : cmd_checker

bind serial_slave_command_handler cmd_checker cmd_checker_inst (
  .clk_sys, .resetn, .frame_end, .tx_ready, .tx_valid, .tx_byte,
  .local_ctrl, .ctrl_word, .ctrl, .commit_pulse, .nv_store_pulse,
  .drive_ready, .comm_error_alarm, .fault_contact);

/* plc_master_model.sv */
// Bus master model: sends request frames, gathers reply bytes.
// Assumes the handler on clk_sys; drives at the falling edge.
module plc_master_model (
  // Clock
  input wire logic                 clk_sys,
  // Request
  output serial_cmd_pkg::rx_byte_s rx,
  output logic                     frame_end,
  // Reply
  output logic                     tx_ready,
  input wire logic                 tx_valid,
  input wire logic [7:0]           tx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  import serial_cmd_pkg::*;
  logic [7:0] reply[$];
  logic       slow = 1'b0;
  logic [1:0] ph = 2'h0;
  logic       echo = 1'b0, ev = 1'b0;
  logic [7:0] eb = 8'h00;
  always @(negedge clk_sys)
    if (echo)
    begin
      rx <= {ev, eb, 3'b000};
      ev <= tx_valid && tx_ready;
      eb <= tx_byte;
    end
  initial rx = '0;
  initial frame_end = 1'b0;
  always @(negedge clk_sys) ph <= ph + 2'h1;
  assign tx_ready = !slow || ph[0];
  always @(posedge clk_sys) if (tx_valid && tx_ready) reply.push_back(tx_byte);
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i])
    begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction : crc16
  // Idle data shows the inverse of the last byte
  task automatic send(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    reply.delete();
    foreach (q[i])
    begin
      @(negedge clk_sys);
      rx <= {1'b1, q[i], 3'b000};
      @(negedge clk_sys);
      rx <= {1'b0, ~q[i], 3'b000};
    end
    frame_end <= 1'b1;
    @(negedge clk_sys);
    frame_end <= 1'b0;
    repeat (40) @(negedge clk_sys);
  endtask : send
endmodule : plc_master_model

/* serial_slave_command_handler_test.sv */
// Testbench for the serial slave command handler.
// Assumes the master model and checker files compiled first.
module serial_slave_command_handler_test;
  timeunit 1ns;
  timeprecision 1ps;
  import serial_cmd_pkg::*;
  logic        clk_sys, resetn, frame_end, tx_ready, tx_valid;
  rx_byte_s    rx;
  logic [7:0]  tx_byte, strap;
  logic [15:0] lc, ctrl_word, speed_setpoint, n_cm = 0, n_nv = 0;
  drive_stat_s st;
  drive_ctrl_s ctrl;
  param_bank_t active_param;
  logic        commit_pulse, nv_store_pulse, st_ok;
  logic        comm_error_alarm, fault_contact, drive_ready;
  int          mismatches = 0, tests_run = 0, cyc = 0;
  plc_master_model plc_inst (.clk_sys, .rx, .frame_end, .tx_ready,
    .tx_valid, .tx_byte);
  serial_slave_command_handler #(.ST_TIMEOUT_CYC(50))
    serial_slave_command_handler_inst (.clk_sys, .resetn, .rx,
    .frame_end, .tx_ready, .tx_valid, .tx_byte, .slave_address(8'h05),
    .input_function_select_fifth(strap), .local_ctrl(lc), .stat(st),
    .ctrl_word, .ctrl, .speed_setpoint, .active_param, .commit_pulse,
    .nv_store_pulse, .selftest_pass(st_ok), .comm_error_alarm,
    .fault_contact, .drive_ready);
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    n_cm += {15'h0, commit_pulse};
    n_nv += {15'h0, nv_store_pulse};
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic chk(input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic req(input logic [7:0] a, f,
    input logic [15:0] s, n, w, input logic bad);
    logic [7:0] q[$];
    q = {a, f, s[15:8], s[7:0], n[15:8], n[7:0]};
    if (f == 8'h10)
      q = {q, 8'h02, w[15:8], w[7:0]};
    plc_inst.send(q, bad);
  endtask : req
  task automatic exc(input logic [3:0] s, input logic [7:0] f,
    input logic [15:0] a, n, w, input logic [7:0] e);
    st = s;
    req(8'h05, f, a, n, w, 1'b0);
    st = '0;
    chk({plc_inst.reply[1], plc_inst.reply[2]}, {f | 8'h80, e});
  endtask : exc
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up
  initial
  begin
    resetn = 1'b0;
    strap = 8'h00;
    lc = 16'h0F0C;
    st = '0;
    repeat (6) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(ctrl_word, 16'h0F0C);
    req(8'h00, 8'h10, 16'h1, 16'h1, 16'h5011, 1'b0);
    chk(16'(plc_inst.reply.size()), 16'h0);
    chk(ctrl_word, 16'h5F1D);
    chk({8'h00, ctrl}, 16'h00AA);
    plc_inst.slow = 1'b1;
    req(8'h05, 8'h03, 16'h1, 16'h1, 16'h0, 1'b0);
    chk({plc_inst.reply[3], plc_inst.reply[4]}, 16'h5011);
    chk(plc_inst.crc16(plc_inst.reply), 16'h0);
    plc_inst.slow = 1'b0;
    req(8'h00, 8'h10, 16'h2, 16'h1, 16'h7530, 1'b0);
    exc(4'h0, 8'h10, 16'h2, 16'h1, 16'h7531, 8'h21);
    chk(speed_setpoint, 16'h7530);
    exc(4'h0, 8'h04, 16'h1, 16'h1, 16'h0, 8'h01);
    exc(4'h0, 8'h03, 16'h0900, 16'h1, 16'h0, 8'h02);
    exc(4'h0, 8'h03, 16'h0910, 16'h1, 16'h0, 8'h02);
    exc(4'h0, 8'h03, 16'h5, 16'h1, 16'h0, 8'h02);
    exc(4'h0, 8'h03, 16'h1, 16'h11, 16'h0, 8'h03);
    exc(4'h0, 8'h10, 16'h0100, 16'h2, 16'h0, 8'h03);
    exc(4'h0, 8'h10, 16'h20, 16'h1, 16'h0, 8'h22);
    exc(4'h0, 8'h10, 16'h0910, 16'h1, 16'h1, 8'h21);
    exc(4'h8, 8'h10, 16'h0910, 16'h1, 16'h0, 8'h22);
    exc(4'h4, 8'h10, 16'h0100, 16'h1, 16'h0, 8'h23);
    exc(4'h2, 8'h10, 16'h0100, 16'h1, 16'h0, 8'h24);
    exc(4'h1, 8'h10, 16'h0106, 16'h1, 16'h0, 8'h22);
    req(8'h05, 8'h10, 16'h0100, 16'h1, 16'h1234, 1'b0);
    chk(active_param[0], 16'h0);
    req(8'h05, 8'h10, 16'h0910, 16'h1, 16'h0, 1'b0);
    chk(active_param[0], 16'h1234);
    chk({n_cm, n_nv}, {16'h1, 16'h0});
    req(8'h00, 8'h10, 16'h0101, 16'h1, 16'h4321, 1'b0);
    req(8'h05, 8'h10, 16'h0900, 16'h1, 16'h0, 1'b0);
    chk(active_param[1], 16'h0);
    chk({n_cm, n_nv}, {16'h2, 16'h1});
    req(8'h05, 8'h03, 16'h1, 16'h1, 16'h0, 1'b1);
    chk(16'(plc_inst.reply.size()), 16'h0);
    req(8'h06, 8'h03, 16'h1, 16'h1, 16'h0, 1'b0);
    chk(16'(plc_inst.reply.size()), 16'h0);
    req(8'h05, 8'h08, 16'h1234, 16'h5678, 16'h0, 1'b0);
    chk({plc_inst.reply[4], plc_inst.reply[5]}, 16'h5678);
    strap = 8'h43;
    for (int k = 0; k < 2; k++)
    begin
      plc_inst.echo = k[0];
      resetn = 1'b0;
      repeat (2) @(negedge clk_sys);
      resetn = 1'b1;
      repeat (400) @(negedge clk_sys);
      chk({st_ok, comm_error_alarm, fault_contact, drive_ready},
        k ? 4'h9 : 4'h6);
    end
    wrap_up();
  end
endmodule : serial_slave_command_handler_test
